//--- verilog/eeprom_pkg.sv
/*
 Constants for the two-wire serial EEPROM front end: array shape, device
 address layout, bit framing and programming time.
 Assumes a 50 MHz core clock.
*/
package eeprom_pkg;
    // Array shape
    localparam int        PAGE_COUNT      = 64;
    localparam int        PAGE_BYTES      = 16;
    localparam int        ADDR_BITS       = 10;
    localparam int        COL_BITS        = 4;
    localparam int        MEM_BYTES       = PAGE_COUNT * PAGE_BYTES;
    localparam logic [ADDR_BITS-1:0] ADDR_MAX = 10'h3FF;

    // Device address word layout
    localparam logic [3:0] DEV_PREFIX     = 4'hA;
    localparam int         DEV_PREFIX_MSB = 7;
    localparam int         DEV_PREFIX_LSB = 4;
    localparam int         DEV_STRAP_POS  = 3;
    localparam int         DEV_HIADDR_MSB = 2;
    localparam int         DEV_HIADDR_LSB = 1;
    localparam int         DEV_RW_POS     = 0;

    // Framing: eight data bits, then the acknowledge clock
    localparam logic [3:0] WORD_BITS      = 4'h8;

    // Write buffer
    localparam int         FIFO_DEPTH     = 32;
    localparam int         FIFO_WIDTH     = ADDR_BITS + 8;

    // Timing
    localparam int         CLK_PERIOD_NS  = 20;
    localparam int         PROG_TIME_NS   = 5000000;
    localparam int         PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;

    // Synchroniser lanes
    localparam int         SYNC_SCL       = 0;
    localparam int         SYNC_SDA       = 1;
    localparam int         SYNC_STRAP     = 2;
    localparam int         SYNC_WP        = 3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WADDR,
        ST_WDATA,
        ST_READ,
        ST_PROG
    } bus_state_t;
endpackage

//--- verilog/eeprom_front_end.sv
/*
 Two-wire bus front end of a 1024 x 8 serial EEPROM, with its write buffer
 FIFO and a flip-flop array standing in for the memory.
 Assumes bus pins are asynchronous to core_clk and that core_clk is well
 above the bus clock, so every bus edge is seen by the oversampler.
*/
`timescale 1ns/10ps

module write_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Drops all content
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // write_fifo

module eeprom_front_end
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES_P = eeprom_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Two-wire bus
    input  wire logic scl_pin,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Straps
    input  wire logic chip_select_strap,
    input  wire logic write_protect,
    // Status
    output logic      standby,
    output logic      prog_busy
);
    import eeprom_pkg::*;

    logic [3:0]            sync1;
    logic [3:0]            sync2;
    logic                  scl_d;
    logic                  sda_d;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    logic                  strap_s;
    logic                  wp_s;
    bus_state_t            state;
    logic [3:0]            bit_cnt;
    logic [7:0]            shift;
    logic [ADDR_BITS-1:0]  word_addr;
    logic [1:0]            hi_addr;
    logic [7:0]            mem [0:MEM_BYTES-1];
    logic [31:0]           prog_cnt;
    logic                  word_end;
    logic                  dev_match;
    logic                  fifo_flush;
    logic                  fifo_in_valid;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic                  fifo_out_ready;
    logic [FIFO_WIDTH-1:0] fifo_out_data;
    logic                  mem_we;

    // Two flip-flops on every pin, then edge flops parked at the idle bus level
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {write_protect, chip_select_strap, sda_in, scl_pin};
            sync2 <= sync1;
            scl_d <= sync2[SYNC_SCL];
            sda_d <= sync2[SYNC_SDA];
        end
    end

    assign strap_s   = sync2[SYNC_STRAP];
    assign wp_s      = sync2[SYNC_WP];
    assign scl_rise  = sync2[SYNC_SCL] && !scl_d;
    assign scl_fall  = !sync2[SYNC_SCL] && scl_d;
    assign start_det = sync2[SYNC_SCL] && scl_d && sda_d && !sync2[SYNC_SDA];
    assign stop_det  = sync2[SYNC_SCL] && scl_d && !sda_d && sync2[SYNC_SDA];
    assign word_end  = scl_fall && (bit_cnt == WORD_BITS);
    assign dev_match = (shift[DEV_PREFIX_MSB:DEV_PREFIX_LSB] == DEV_PREFIX)
                    && (shift[DEV_STRAP_POS] == strap_s);
    // any start outside programming clears the bus logic and buffer
    assign fifo_flush     = start_det && (state != ST_PROG);
    assign fifo_in_valid  = word_end && (state == ST_WDATA);
    assign fifo_out_ready = (state == ST_PROG);
    // write protect gates the array write
    assign mem_we         = fifo_out_valid && fifo_out_ready && !wp_s;

    write_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_write_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .flush     (fifo_flush),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({word_addr, shift}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[fifo_out_data[FIFO_WIDTH-1:8]] <= fifo_out_data[7:0];
        end
    end

    // Bus state
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else if (state == ST_PROG) begin
            // standby once time and buffer are both done
            if (prog_cnt == 32'h0 && !fifo_out_valid) begin
                state <= ST_IDLE;
            end
        end else if (start_det) begin
            state <= ST_DEV;
        end else if (stop_det) begin
            // stop with an empty buffer goes straight to standby; stop with buffered bytes programs
            state <= fifo_out_valid ? ST_PROG : ST_IDLE;
        end else if (word_end) begin
            case (state)
                ST_DEV: begin
                    if (!dev_match) begin
                        state <= ST_IDLE;
                    end else if (shift[DEV_RW_POS]) begin
                        state <= ST_READ;
                    end else begin
                        state <= ST_WADDR;
                    end
                end
                ST_WADDR: state <= ST_WDATA;
                default:  state <= state;
            endcase
        end else if (scl_rise && state == ST_READ && bit_cnt == WORD_BITS && sync2[SYNC_SDA]) begin
            // Host did not acknowledge: wait for stop in standby
            state <= ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_cnt <= 32'h0;
        end else if (state != ST_PROG && stop_det && fifo_out_valid) begin
            prog_cnt <= 32'(PROG_CYCLES_P - 1);
        end else if (state == ST_PROG && prog_cnt != 32'h0) begin
            prog_cnt <= prog_cnt - 32'h1;
        end
    end

    // Bit counter and shift register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else if (fifo_flush) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && state != ST_IDLE && state != ST_PROG) begin
            // eight bits then the acknowledge clock
            if (bit_cnt == WORD_BITS) begin
                bit_cnt <= 4'h0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (state != ST_READ && bit_cnt != WORD_BITS) begin
                shift <= {shift[6:0], sync2[SYNC_SDA]};
            end
        end else if (scl_fall && state == ST_READ) begin
            if (bit_cnt == 4'h0) begin
                shift <= {mem[word_addr][6:0], 1'b1};
            end else if (bit_cnt != WORD_BITS) begin
                shift <= {shift[6:0], 1'b1};
            end
        end
    end

    // Word address counter
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_addr <= '0;
            hi_addr   <= 2'h0;
        end else if (word_end && state == ST_DEV) begin
            hi_addr <= shift[DEV_HIADDR_MSB:DEV_HIADDR_LSB];
        end else if (word_end && state == ST_WADDR) begin
            // upper bits come from the device address
            word_addr <= {hi_addr, shift};
        end else if (fifo_in_valid && fifo_in_ready) begin
            word_addr <= {word_addr[ADDR_BITS-1:COL_BITS], word_addr[COL_BITS-1:0] + 4'h1};
        end else if (scl_fall && state == ST_READ && bit_cnt == 4'h0) begin
            // read wraps from top to zero
            word_addr <= (word_addr == ADDR_MAX) ? '0 : word_addr + 1'b1;
        end
    end

    // Data line driver; only ever pulls low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (state == ST_PROG || state == ST_IDLE || fifo_flush) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            // drive changes only after the falling edge
            // open-drain: enable low bit, release high bit
            if (bit_cnt == WORD_BITS) begin
                case (state)
                    ST_DEV:   sda_oe <= dev_match;
                    ST_WADDR: sda_oe <= 1'b1;
                    // Full buffer refuses the byte rather than dropping it
                    ST_WDATA: sda_oe <= fifo_in_ready;
                    default:  sda_oe <= 1'b0;
                endcase
            end else if (state == ST_READ) begin
                sda_oe <= (bit_cnt == 4'h0) ? !mem[word_addr][7] : !shift[7];
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // Status
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            standby   <= 1'b1;
            prog_busy <= 1'b0;
        end else begin
            standby   <= (state == ST_IDLE);
            prog_busy <= (state == ST_PROG);
        end
    end

    a_open_drain_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        sda_oe |-> !sda_out) else $error("data line driven high");
    a_drive_after_fall: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($rose(sda_oe) || ($fell(sda_oe) && $past(state) != ST_PROG && $past(state) != ST_IDLE
            && !$past(fifo_flush))) |-> $past(scl_fall)) else $error("drive changed off clock fall");
    a_start_enters_dev: assert property (@(posedge core_clk) disable iff (!reset_n)
        (start_det && state != ST_PROG) |=> (state == ST_DEV && bit_cnt == 4'h0))
        else $error("start not taken");
    a_read_stop_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (stop_det && (state == ST_READ || state == ST_IDLE) && !fifo_out_valid) |=> state == ST_IDLE ##1 standby)
        else $error("read stop not to standby");
    a_write_stop_prog: assert property (@(posedge core_clk) disable iff (!reset_n)
        (stop_det && state == ST_WDATA && fifo_out_valid) |=> state == ST_PROG ##1 prog_busy)
        else $error("write stop did not program");
    a_prog_ends_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == ST_PROG && prog_cnt == 32'h0 && !fifo_out_valid) |=> state == ST_IDLE)
        else $error("programming did not end");
    a_ack_ninth_clock: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_end && state == ST_WADDR && !start_det && !stop_det) |=> sda_oe)
        else $error("no acknowledge on word address");
    a_prefix_mismatch: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_end && state == ST_DEV && !start_det && !stop_det && shift[7:4] != DEV_PREFIX)
        |=> (!sda_oe && state == ST_IDLE)) else $error("foreign address acknowledged");
    a_dir_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_end && state == ST_DEV && !start_det && !stop_det && dev_match && shift[0])
        |=> (state == ST_READ && sda_oe)) else $error("read direction not decoded");
    a_prog_silent: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == ST_PROG |=> !sda_oe) else $error("acknowledge during programming");
    a_wp_blocks: assert property (@(posedge core_clk) disable iff (!reset_n)
        mem_we |-> !wp_s) else $error("write while protected");
    a_page_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
        (fifo_in_valid && fifo_in_ready) |=> (word_addr[9:4] == $past(word_addr[9:4])
        && word_addr[3:0] == 4'($past(word_addr[3:0]) + 4'h1))) else $error("page column wrong");
    a_read_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
        (scl_fall && state == ST_READ && bit_cnt == 4'h0 && word_addr == ADDR_MAX && !start_det && !stop_det)
        |=> word_addr == '0) else $error("read address did not wrap");
endmodule // eeprom_front_end

//--- bench/bus_host.sv
/*
 Behavioural two-wire bus host: start, stop, byte send and byte receive.
 Assumes the bench resolves the open-drain data wire and feeds it to sda.
*/
`timescale 1ns/10ps

module bus_host (
    // Clock
    input  wire logic core_clk,
    // Bus wire
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // Idle bus: clock parked high, data released
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic bit_io(input logic b, output logic seen);
        tick(2);
        sda_low = !b;
        tick(3);
        scl = 1'h1;
        tick(3);
        seen = sda;
        scl = 1'h0;
    endtask

    task automatic start();
        tick(2);
        sda_low = 1'h0;
        tick(3);
        scl = 1'h1;
        tick(3);
        sda_low = 1'h1;
        tick(3);
        scl = 1'h0;
    endtask

    task automatic stop();
        tick(2);
        sda_low = 1'h1;
        tick(3);
        scl = 1'h1;
        tick(3);
        sda_low = 1'h0;
        tick(3);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'h1, s);
        ack = !s;
    endtask

    // Host acknowledges all bytes but the last
    task automatic recv(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
        bit_io(nack, s);
    endtask
endmodule // bus_host

//--- bench/eeprom_front_end_tb.sv
/*
 Self-checking bench for the EEPROM bus front end: addressing, page write,
 polling, reads, write protect, full buffer and bus soft reset.
 Assumes programming shortened to 400 core cycles.
*/
`timescale 1ns/10ps

module eeprom_front_end_tb;
    import eeprom_pkg::*;

    logic       core_clk          = 1'h0;
    logic       reset_n;
    logic       chip_select_strap;
    logic       write_protect;
    logic       scl_pin;
    logic       sda_low;
    logic       sda_in;
    logic       sda_out;
    logic       sda_oe;
    logic       standby;
    logic       prog_busy;
    logic       ack;
    logic [7:0] got [0:3];
    int         n_fail = 0;
    int         checks = 0;

    // Wire is low if either party pulls, else held high by the pull-up
    assign sda_in = ~((sda_oe & ~sda_out) | sda_low);

    always #10 core_clk = ~core_clk;

    eeprom_front_end #(.PROG_CYCLES_P(400)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .scl_pin(scl_pin), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap(chip_select_strap),
        .write_protect(write_protect), .standby(standby), .prog_busy(prog_busy));

    bus_host host (.core_clk(core_clk), .sda(sda_in), .scl(scl_pin), .sda_low(sda_low));

    task automatic test_done();
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Sampled at the falling edge, where the design's registered outputs have settled
    logic prev_oe = 1'h0;
    always @(negedge core_clk) begin
        if (reset_n && sda_oe !== prev_oe) chk("scl at oe change", 8'h00, {7'h0, scl_pin});
        if (reset_n && sda_oe === 1'h1) chk("sda_out", 8'h00, {7'h0, sda_out});
        prev_oe <= sda_oe;
    end

    task automatic dev(input logic [7:0] b, input logic exp, input string what);
        host.start();
        host.send(b, ack);
        chk(what, {7'h0, exp}, {7'h0, ack});
    endtask

    task automatic wr(input logic [9:0] a, input int n, input logic [7:0] v);
        logic [7:0] dvb;
        dvb = {4'hA, chip_select_strap, a[9:8], 1'h0};
        dev(dvb, 1'h1, "dev ack");
        host.send(a[7:0], ack);
        chk("addr ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            host.send(v + 8'(i) * 8'h11, ack);
            chk("data ack", 8'(i < FIFO_DEPTH), {7'h0, ack});
        end
        host.stop();
        host.tick(8);
        chk("prog_busy", 8'h01, {7'h0, prog_busy});
        chk("standby in prog", 8'h00, {7'h0, standby});
        dev(dvb, 1'h0, "busy poll");
        host.stop();
        for (int k = 0; k < 20 && !ack; k++) begin
            host.start();
            host.send(dvb, ack);
            host.stop();
        end
        chk("poll ack", 8'h01, {7'h0, ack});
        if (!ack) test_done();
        host.tick(8);
        chk("standby after prog", 8'h01, {7'h0, standby});
    endtask

    task automatic rd(input logic [9:0] a, input int n);
        dev({4'hA, chip_select_strap, a[9:8], 1'h0}, 1'h1, "dummy ack");
        host.send(a[7:0], ack);
        chk("addr ack", 8'h01, {7'h0, ack});
        dev({4'hA, chip_select_strap, 3'h1}, 1'h1, "read ack");
        for (int i = 0; i < n; i++) host.recv(got[i], i == n - 1);
        host.stop();
        host.tick(8);
        chk("standby after read", 8'h01, {7'h0, standby});
    endtask

    initial begin
        logic s;
        reset_n = 1'h0;
        chip_select_strap = 1'h0;
        write_protect = 1'h0;
        repeat (8) @(negedge core_clk);
        reset_n = 1'h1;
        chk("reset standby", 8'h01, {7'h0, standby});
        chk("reset prog_busy", 8'h00, {7'h0, prog_busy});
        chk("reset oe", 8'h00, {7'h0, sda_oe});
        host.tick(4);
        for (int j = 0; j < 2; j++) begin
            s = 1'(j);
            chip_select_strap = s;
            host.tick(4);
            dev({4'hA, s, 3'h0}, 1'h1, "strap match");
            host.stop();
            dev({4'hA, !s, 3'h0}, 1'h0, "strap miss");
            host.stop();
        end
        dev(8'hB0, 1'h0, "prefix miss");
        host.stop();
        chip_select_strap = 1'h0;
        host.tick(4);
        wr(10'h3FE, 3, 8'h11);
        wr(10'h000, 1, 8'h44);
        rd(10'h3FE, 3);
        chk("rd 3FE", 8'h11, got[0]);
        chk("rd 3FF", 8'h22, got[1]);
        chk("rd wrap 000", 8'h44, got[2]);
        rd(10'h3F0, 1);
        chk("rd page wrap", 8'h33, got[0]);
        // A full buffer refuses the 33rd byte; protected data never lands
        write_protect = 1'h1;
        wr(10'h000, 33, 8'h90);
        rd(10'h000, 1);
        chk("rd protected", 8'h44, got[0]);
        write_protect = 1'h0;
        // Interrupted write, then start, eighteen ones, start
        dev(8'hA0, 1'h1, "dev ack");
        for (int i = 0; i < 3; i++) host.bit_io(1'h0, s);
        host.start();
        for (int i = 0; i < 18; i++) host.bit_io(1'h1, s);
        host.start();
        host.send(8'hA0, ack);
        chk("soft reset ack", 8'h01, {7'h0, ack});
        host.stop();
        host.tick(8);
        chk("standby idle", 8'h01, {7'h0, standby});
        test_done();
    end
endmodule // eeprom_front_end_tb
